/* tb/line_media_model.sv */
// line media model that drives both serial input pairs of every channel
`timescale 1ns/10ps
module line_media_model (
  // clock
  input  wire logic aclk,
  // line side
  output logic [3:0] primary_serial_in,
  output logic [3:0] secondary_serial_in
);
  integer seed = 11;

  ////////////////////////////////////////////////////////////////////////////
  // fresh data every cycle, so a stale select or a leaking input shows at once
  initial begin
    primary_serial_in   = 4'h0;
    secondary_serial_in = 4'hf;
  end

  always @(posedge aclk) begin
    primary_serial_in   <= 4'($random(seed));
    secondary_serial_in <= 4'($random(seed));
  end
endmodule : line_media_model

/* tb/serial_port_select_loopback_bench.sv */
// self-checking bench for the serial input select, loopback and driver enable latch
`timescale 1ns/10ps
module serial_port_select_loopback_bench;
  typedef struct packed {
    logic [3:0] sel;
    logic       loop;
    logic [7:0] en;
    logic [1:0] det;
  } line_cfg_s;
  typedef struct packed {
    logic [31:0] data;
    logic [1:0]  resp;
    logic        chk;
  } read_exp_s;

  logic        aclk, aresetn, check_req, open;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, serial_out_pair, en_reg;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb, primary_serial_in, secondary_serial_in, tx_serial_stream;
  logic [3:0]  cdr_serial_in, prev_p, prev_s, prev_tx;
  logic [1:0]  s_axi_bresp, s_axi_rresp, detect_threshold;
  int          fail_count, checks, cycles;
  integer      seed = 11;
  line_cfg_s   cfg;
  line_cfg_s   line_q[$];
  read_exp_s   read_q[$];
  logic [1:0]  resp_q[$];

  serial_port_select_loopback dut_u (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .primary_serial_in(primary_serial_in), .secondary_serial_in(secondary_serial_in),
    .tx_serial_stream(tx_serial_stream), .serial_out_pair(serial_out_pair),
    .cdr_serial_in(cdr_serial_in), .detect_threshold(detect_threshold));

  line_media_model media_u (.aclk(aclk), .primary_serial_in(primary_serial_in),
    .secondary_serial_in(secondary_serial_in));

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  // inputs seen by the design at the last edge, for the line compare
  always @(posedge aclk) begin
    tx_serial_stream <= 4'($random(seed));
    prev_p           <= primary_serial_in;
    prev_s           <= secondary_serial_in;
    prev_tx          <= tx_serial_stream;
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      $display("Error at %0t: timeout", $time);
      end_sim();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic mismatch(input string msg);
    fail_count++;
    $display("Error at %0t: %s", $time, msg);
  endtask : mismatch

  task automatic cmp_line(input line_cfg_s c);
    logic [7:0] eo;
    logic [3:0] ec;
    for (int i = 0; i < 4; i++) begin
      ec[i]       = c.loop ? prev_tx[i] : (c.sel[i] ? prev_p[i] : prev_s[i]);
      eo[2*i]     = c.en[2*i] & (c.loop | prev_tx[i]);
      eo[2*i + 1] = c.en[2*i + 1] & (c.loop | prev_tx[i]);
    end
    checks++;
    if (serial_out_pair !== eo || cdr_serial_in !== ec || detect_threshold !== c.det)
      mismatch($sformatf("line %h %h %h exp %h %h %h", serial_out_pair, cdr_serial_in,
               detect_threshold, eo, ec, c.det));
  endtask : cmp_line

  task automatic cmp_read(input read_exp_s e);
    checks++;
    if (s_axi_rresp !== e.resp || (e.chk && s_axi_rdata !== e.data))
      mismatch($sformatf("read %h/%h exp %h/%h", s_axi_rdata, s_axi_rresp, e.data, e.resp));
  endtask : cmp_read

  task automatic cmp_resp(input logic [1:0] e);
    checks++;
    if (s_axi_bresp !== e) mismatch($sformatf("bresp %h exp %h", s_axi_bresp, e));
  endtask : cmp_resp

  always @(negedge aclk) begin
    if (check_req && line_q.size() > 0) begin
      cmp_line(line_q.pop_front());
    end
  end

  always @(posedge aclk) begin
    if (s_axi_rvalid && s_axi_rready && read_q.size() > 0) begin
      cmp_read(read_q.pop_front());
    end
    if (s_axi_bvalid && s_axi_bready && resp_q.size() > 0) cmp_resp(resp_q.pop_front());
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    resp_q.push_back(r);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!(s_axi_bvalid && s_axi_bready) && n < 100);
    s_axi_bready <= 1'b0;
    if (n >= 100) mismatch("write hung");
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r,
                          input logic k);
    int n;
    n = 0;
    @(posedge aclk);
    read_q.push_back('{d, r, k});
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!(s_axi_rvalid && s_axi_rready) && n < 100);
    s_axi_rready <= 1'b0;
    if (n >= 100) mismatch("read hung");
  endtask : axi_read

  task automatic set_ctrl(input logic [3:0] s, input logic lp, input logic op,
                          input logic [1:0] dt);
    axi_write(serial_port_pkg::CTRL_OFFSET, {22'h0, dt, 2'h0, op, lp, s},
              serial_port_pkg::RESP_OKAY);
    cfg.sel  = s;
    cfg.loop = lp;
    cfg.det  = dt;
    open     = op;
    if (op) cfg.en = en_reg;
  endtask : set_ctrl

  task automatic set_en(input logic [7:0] v);
    axi_write(serial_port_pkg::ENABLE_OFFSET, {24'h0, v}, serial_port_pkg::RESP_OKAY);
    en_reg = v;
    if (open) cfg.en = v;
  endtask : set_en

  task automatic read_status(input logic [31:0] d);
    axi_read(serial_port_pkg::STATUS_OFFSET, d, serial_port_pkg::RESP_OKAY, 1'b1);
  endtask : read_status

  // line outputs trail a register write by one flop, so two edges settle them
  task automatic line_check();
    repeat (2) @(posedge aclk);
    line_q.push_back(cfg);
    check_req <= 1'b1;
    @(posedge aclk);
    check_req <= 1'b0;
  endtask : line_check

  task automatic do_reset();
    aresetn <= 1'b0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    cfg    = '0;
    en_reg = 8'h00;
    open   = 1'b0;
    @(posedge aclk);
  endtask : do_reset

  task automatic end_sim();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_sim

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, check_req} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb      = 4'hf;
    aresetn          = 1'b0;
    do_reset();
    line_check();
    axi_read(serial_port_pkg::CTRL_OFFSET, 32'h0000_0000, serial_port_pkg::RESP_OKAY, 1'b1);
    read_status(32'h0000_0000);
    // open latch: random enables and selects, every detect level, held between checks
    for (int i = 0; i < 6; i++) begin
      set_ctrl(4'($random(seed)), 1'b0, 1'b1, 2'(i % 3));
      set_en(8'($random(seed)));
      line_check();
      read_status({24'h0, cfg.en});
    end
    // closing the latch holds the enables while the bus moves on
    set_en(8'h5a);
    set_ctrl(4'ha, 1'b0, 1'b0, 2'h1);
    set_en(8'ha5);
    line_check();
    read_status(32'h0000_005a);
    axi_read(serial_port_pkg::CTRL_OFFSET, 32'h0000_010a, serial_port_pkg::RESP_OKAY, 1'b1);
    set_ctrl(4'ha, 1'b0, 1'b1, 2'h1);
    line_check();
    // loopback with part of the drivers off, then back out
    set_en(8'h3c);
    set_ctrl(4'h5, 1'b1, 1'b1, 2'h2);
    line_check();
    axi_read(serial_port_pkg::STATUS_OFFSET, 32'h0000_013c, serial_port_pkg::RESP_OKAY, 1'b1);
    set_ctrl(4'h5, 1'b0, 1'b1, 2'h2);
    line_check();
    // unmapped place refused without side effect
    axi_write(8'h0c, 32'hffff_ffff, serial_port_pkg::RESP_SLVERR);
    axi_read(8'h0c, 32'h0000_0000, serial_port_pkg::RESP_SLVERR, 1'b0);
    line_check();
    // reset in mid-run turns every driver off
    do_reset();
    line_check();
    read_status(32'h0000_0000);
    end_sim();
  end
endmodule : serial_port_select_loopback_bench

/* verilog/serial_lane_if.sv */
// per-channel serial lane signals between the top and the lane mux
`timescale 1ns/10ps
interface serial_lane_if;
  logic       primary_in;
  logic       secondary_in;
  logic       tx_stream;
  logic       select;
  logic       loopback;
  logic [1:0] driver_en;
  logic       cdr_in;
  logic [1:0] serial_out;
  modport top  (output primary_in, secondary_in, tx_stream, select, loopback, driver_en,
                input cdr_in, serial_out);
  modport lane (input primary_in, secondary_in, tx_stream, select, loopback, driver_en,
                output cdr_in, serial_out);
endinterface : serial_lane_if

/* verilog/serial_lane_mux.sv */
// one channel's input selection, loopback routing and driver data forcing
`timescale 1ns/10ps
module serial_lane_mux (
  serial_lane_if.lane lane
);
  always_comb begin
    // loopback ignores both external inputs whatever the select says
    if (lane.loopback) begin
      lane.cdr_in = lane.tx_stream;
    end else if (lane.select) begin
      lane.cdr_in = lane.primary_in;
    end else begin
      lane.cdr_in = lane.secondary_in;
    end
  end

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      // disabled drivers are powered down and sit at zero here
      if (!lane.driver_en[i]) begin
        lane.serial_out[i] = 1'b0;
      end else if (lane.loopback) begin
        lane.serial_out[i] = 1'b1;
      end else begin
        lane.serial_out[i] = lane.tx_stream;
      end
    end
  end
endmodule : serial_lane_mux

/* verilog/serial_port_pkg.sv */
// shared constants and register map for the serial port select and loopback block
package serial_port_pkg;
  localparam int NUM_CHANNELS = 4;
  localparam int NUM_DRIVERS  = 8;

  // register byte offsets
  localparam logic [7:0] CTRL_OFFSET   = 8'h00;
  localparam logic [7:0] ENABLE_OFFSET = 8'h04;
  localparam logic [7:0] STATUS_OFFSET = 8'h08;

  // control register field positions
  localparam int CTRL_SELECT_LSB   = 0;
  localparam int CTRL_LOOPBACK_BIT = 4;
  localparam int CTRL_LATCH_BIT    = 5;
  localparam int CTRL_DETECT_LSB   = 8;

  // enable register field positions
  localparam int ENABLE_BUS_LSB = 0;

  // status register field positions
  localparam int STATUS_ENABLES_LSB  = 0;
  localparam int STATUS_LOOPBACK_BIT = 8;

  // reset values
  localparam logic [3:0] SELECT_RESET  = 4'h0;
  localparam logic [7:0] ENABLE_RESET  = 8'h00;
  localparam logic [1:0] DETECT_RESET  = 2'h0;

  // axi response codes
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // detect level encoding of the three-level static input
  typedef enum logic [1:0] {
    DETECT_LOW,
    DETECT_MID,
    DETECT_HIGH
  } detect_level_e;
endpackage : serial_port_pkg

/* verilog/serial_port_select_loopback.sv */
// serial input select, loopback and driver enable latch with an axi4-lite register slave
// Functional notes
// - each recovery stage takes the primary input when its select is high, else the secondary.
// - with loopback on, each channel's transmit stream feeds its own recovery stage.
// - with loopback on, every enabled driver sends a constant one.
// - with loopback on, all external serial inputs are ignored.
// - while the latch control is high the eight enable bits pass straight to the drivers.
// - a driver is on when its enable bit is high and powered down when low.
// - when the latch control falls, the enable bits present are held until it opens again.
// - reset clears the enable latch so all drivers are off.
// - reset is active low, sampled on the clock edge, and initialises all state.
`timescale 1ns/10ps
module serial_port_select_loopback (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write address
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [7:0]  s_axi_awaddr,
  // axi4-lite write data
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  // axi4-lite write response
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  // axi4-lite read address
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [7:0]  s_axi_araddr,
  // axi4-lite read data
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  // serial line side
  input  wire logic [3:0]  primary_serial_in,
  input  wire logic [3:0]  secondary_serial_in,
  input  wire logic [3:0]  tx_serial_stream,
  output logic [7:0]       serial_out_pair,
  output logic [3:0]       cdr_serial_in,
  output logic [1:0]       detect_threshold
);
  ////////////////////////////////////////////////////////////////////////////
  // register state
  logic [3:0] rx_input_select_reg, rx_input_select_next;
  logic       loopback_enable_reg, loopback_enable_next;
  logic       driver_enable_latch_open_reg, driver_enable_latch_open_next;
  logic [7:0] shared_enable_bus_reg, shared_enable_bus_next;
  logic [1:0] detect_level_select_reg, detect_level_select_next;
  logic [7:0] driver_latch_reg, driver_latch_next;

  logic        awready_reg, awready_next;
  logic        wready_reg, wready_next;
  logic        aw_held_reg, aw_held_next;
  logic        w_held_reg, w_held_next;
  logic [7:0]  waddr_reg, waddr_next;
  logic [31:0] wdata_reg, wdata_next;
  logic [3:0]  wstrb_reg, wstrb_next;
  logic        bvalid_reg, bvalid_next;
  logic [1:0]  bresp_reg, bresp_next;
  logic        arready_reg, arready_next;
  logic        rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0]  rresp_reg, rresp_next;
  logic [7:0]  serial_out_reg;
  logic [3:0]  cdr_in_reg;
  logic [1:0]  detect_out_reg;

  logic       do_write;
  logic [7:0] driver_enables;
  logic [7:0] lane_out;
  logic [3:0] lane_cdr;

  ////////////////////////////////////////////////////////////////////////////
  // axi write channel
  assign do_write = aw_held_reg && w_held_reg && !bvalid_reg;

  always_comb begin
    awready_next  = awready_reg;
    wready_next   = wready_reg;
    aw_held_next  = aw_held_reg;
    w_held_next   = w_held_reg;
    waddr_next    = waddr_reg;
    wdata_next    = wdata_reg;
    wstrb_next    = wstrb_reg;
    bvalid_next   = bvalid_reg;
    bresp_next    = bresp_reg;
    rx_input_select_next          = rx_input_select_reg;
    loopback_enable_next          = loopback_enable_reg;
    driver_enable_latch_open_next = driver_enable_latch_open_reg;
    shared_enable_bus_next        = shared_enable_bus_reg;
    detect_level_select_next      = detect_level_select_reg;
    if (s_axi_awvalid && awready_reg) begin
      aw_held_next = 1'b1;
      waddr_next   = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_reg) begin
      w_held_next = 1'b1;
      wdata_next  = s_axi_wdata;
      wstrb_next  = s_axi_wstrb;
    end
    awready_next = !aw_held_next && !bvalid_reg;
    wready_next  = !w_held_next && !bvalid_reg;
    if (do_write) begin
      aw_held_next = 1'b0;
      w_held_next  = 1'b0;
      awready_next = 1'b0;
      wready_next  = 1'b0;
      bvalid_next  = 1'b1;
      bresp_next   = serial_port_pkg::RESP_OKAY;
      unique case (waddr_reg)
        serial_port_pkg::CTRL_OFFSET: begin
          if (wstrb_reg[0]) begin
            rx_input_select_next = wdata_reg[serial_port_pkg::CTRL_SELECT_LSB +: 4];
            loopback_enable_next = wdata_reg[serial_port_pkg::CTRL_LOOPBACK_BIT];
            driver_enable_latch_open_next = wdata_reg[serial_port_pkg::CTRL_LATCH_BIT];
          end
          if (wstrb_reg[1]) begin
            detect_level_select_next = wdata_reg[serial_port_pkg::CTRL_DETECT_LSB +: 2];
          end
        end
        serial_port_pkg::ENABLE_OFFSET: begin
          if (wstrb_reg[0]) begin
            shared_enable_bus_next = wdata_reg[serial_port_pkg::ENABLE_BUS_LSB +: 8];
          end
        end
        serial_port_pkg::STATUS_OFFSET: ;
        default: bresp_next = serial_port_pkg::RESP_SLVERR;
      endcase
    end
    if (bvalid_reg && s_axi_bready) begin
      bvalid_next  = 1'b0;
      awready_next = !aw_held_next;
      wready_next  = !w_held_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // driver enable latch: transparent while open, holds on close
  always_comb begin
    driver_latch_next = driver_latch_reg;
    if (driver_enable_latch_open_reg) begin
      driver_latch_next = shared_enable_bus_reg;
    end
  end

  // open latch shows the bus at once; closed latch shows the captured value
  assign driver_enables = driver_enable_latch_open_reg ? shared_enable_bus_reg
                                                       : driver_latch_reg;

  ////////////////////////////////////////////////////////////////////////////
  // axi read channel
  always_comb begin
    arready_next = arready_reg;
    rvalid_next  = rvalid_reg;
    rdata_next   = rdata_reg;
    rresp_next   = rresp_reg;
    if (s_axi_arvalid && arready_reg) begin
      arready_next = 1'b0;
      rvalid_next  = 1'b1;
      rresp_next   = serial_port_pkg::RESP_OKAY;
      rdata_next   = 32'h0000_0000;
      unique case (s_axi_araddr)
        serial_port_pkg::CTRL_OFFSET: begin
          rdata_next[serial_port_pkg::CTRL_SELECT_LSB +: 4]  = rx_input_select_reg;
          rdata_next[serial_port_pkg::CTRL_LOOPBACK_BIT]     = loopback_enable_reg;
          rdata_next[serial_port_pkg::CTRL_LATCH_BIT]        = driver_enable_latch_open_reg;
          rdata_next[serial_port_pkg::CTRL_DETECT_LSB +: 2]  = detect_level_select_reg;
        end
        serial_port_pkg::ENABLE_OFFSET: begin
          rdata_next[serial_port_pkg::ENABLE_BUS_LSB +: 8] = shared_enable_bus_reg;
        end
        serial_port_pkg::STATUS_OFFSET: begin
          rdata_next[serial_port_pkg::STATUS_ENABLES_LSB +: 8] = driver_enables;
          rdata_next[serial_port_pkg::STATUS_LOOPBACK_BIT]     = loopback_enable_reg;
        end
        default: rresp_next = serial_port_pkg::RESP_SLVERR;
      endcase
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_next  = 1'b0;
      arready_next = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-channel lanes; bit 2c is primary driver, 2c+1 secondary
  for (genvar c = 0; c < serial_port_pkg::NUM_CHANNELS; c++) begin : g_lane
    serial_lane_if lane_bus ();
    assign lane_bus.primary_in   = primary_serial_in[c];
    assign lane_bus.secondary_in = secondary_serial_in[c];
    assign lane_bus.tx_stream    = tx_serial_stream[c];
    assign lane_bus.select       = rx_input_select_reg[c];
    assign lane_bus.loopback     = loopback_enable_reg;
    assign lane_bus.driver_en    = driver_enables[2*c +: 2];
    assign lane_out[2*c +: 2]    = lane_bus.serial_out;
    assign lane_cdr[c]           = lane_bus.cdr_in;
    serial_lane_mux u_lane (
      .lane (lane_bus.lane)
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // state registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_reg <= 1'b0;
      wready_reg  <= 1'b0;
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
      waddr_reg   <= 8'h00;
      wdata_reg   <= 32'h0000_0000;
      wstrb_reg   <= 4'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= serial_port_pkg::RESP_OKAY;
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h0000_0000;
      rresp_reg   <= serial_port_pkg::RESP_OKAY;
      rx_input_select_reg          <= serial_port_pkg::SELECT_RESET;
      loopback_enable_reg          <= 1'b0;
      driver_enable_latch_open_reg <= 1'b0;
      shared_enable_bus_reg        <= serial_port_pkg::ENABLE_RESET;
      detect_level_select_reg      <= serial_port_pkg::DETECT_RESET;
      driver_latch_reg             <= serial_port_pkg::ENABLE_RESET;
      serial_out_reg               <= 8'h00;
      cdr_in_reg                   <= 4'h0;
      detect_out_reg               <= serial_port_pkg::DETECT_RESET;
    end else begin
      awready_reg <= awready_next;
      wready_reg  <= wready_next;
      aw_held_reg <= aw_held_next;
      w_held_reg  <= w_held_next;
      waddr_reg   <= waddr_next;
      wdata_reg   <= wdata_next;
      wstrb_reg   <= wstrb_next;
      bvalid_reg  <= bvalid_next;
      bresp_reg   <= bresp_next;
      arready_reg <= (arready_reg || rvalid_reg) ? arready_next : 1'b1;
      rvalid_reg  <= rvalid_next;
      rdata_reg   <= rdata_next;
      rresp_reg   <= rresp_next;
      rx_input_select_reg          <= rx_input_select_next;
      loopback_enable_reg          <= loopback_enable_next;
      driver_enable_latch_open_reg <= driver_enable_latch_open_next;
      shared_enable_bus_reg        <= shared_enable_bus_next;
      detect_level_select_reg      <= detect_level_select_next;
      driver_latch_reg             <= driver_latch_next;
      serial_out_reg               <= lane_out;
      cdr_in_reg                   <= lane_cdr;
      detect_out_reg               <= detect_level_select_reg;
    end
  end

  assign s_axi_awready    = awready_reg;
  assign s_axi_wready     = wready_reg;
  assign s_axi_bvalid     = bvalid_reg;
  assign s_axi_bresp      = bresp_reg;
  assign s_axi_arready    = arready_reg;
  assign s_axi_rvalid     = rvalid_reg;
  assign s_axi_rdata      = rdata_reg;
  assign s_axi_rresp      = rresp_reg;
  assign serial_out_pair  = serial_out_reg;
  assign cdr_serial_in    = cdr_in_reg;
  assign detect_threshold = detect_out_reg;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  loop_forces_one_a: assert property (@(posedge aclk) disable iff (!aresetn)
    loopback_enable_reg && driver_enables[0] |=> serial_out_reg[0])
    else $error("enabled driver not forced high in loopback");
  loop_routes_tx_a: assert property (@(posedge aclk) disable iff (!aresetn)
    loopback_enable_reg |=> cdr_in_reg == $past(tx_serial_stream))
    else $error("loopback did not route transmit stream");
  loop_ignores_in_a: assert property (@(posedge aclk) disable iff (!aresetn)
    loopback_enable_reg && !tx_serial_stream[1] |=> !cdr_in_reg[1])
    else $error("external input leaked in loopback");
  select_primary_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !loopback_enable_reg && rx_input_select_reg[2]
      |=> cdr_in_reg[2] == $past(primary_serial_in[2]))
    else $error("primary input not selected");
  select_secondary_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !loopback_enable_reg && !rx_input_select_reg[3]
      |=> cdr_in_reg[3] == $past(secondary_serial_in[3]))
    else $error("secondary input not selected");
  latch_transparent_a: assert property (@(posedge aclk) disable iff (!aresetn)
    driver_enable_latch_open_reg && !loopback_enable_reg
      |=> serial_out_reg[1] == ($past(shared_enable_bus_reg[1]) && $past(tx_serial_stream[0])))
    else $error("open latch not transparent");
  latch_holds_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $fell(driver_enable_latch_open_reg) |-> driver_enables == $past(shared_enable_bus_reg))
    else $error("closed latch did not capture value");
  latch_keeps_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !driver_enable_latch_open_reg
      |=> (!driver_enable_latch_open_reg |-> $stable(driver_enables)))
    else $error("closed latch did not hold value");
  driver_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !driver_enables[5] |=> !serial_out_reg[5])
    else $error("disabled driver is active");
  reset_clears_a: assert property (@(posedge aclk)
    !aresetn |=> driver_latch_reg == 8'h00 && serial_out_reg == 8'h00)
    else $error("reset did not disable drivers");
endmodule : serial_port_select_loopback
